// [rtl/wom_defs.svh]
`ifndef WOM_DEFS_SVH
`define WOM_DEFS_SVH

// register indices, byte address is four times the index
`define WOM_IDX_MODE 10'h0A6
`define WOM_IDX_STAT 10'h0AF

// reset values
`define WOM_MODE_RST 8'h00

// mode register fields
`define WOM_SEL_HI 2
`define WOM_SEL_LO 0
`define WOM_B_SUB 3
`define WOM_B_TPSUB 4
`define WOM_B_PWM_HI 5
`define WOM_B_PWM_LO 4
`define WOM_B_BIT5 5
`define WOM_B_DTRIG 6
`define WOM_B_OUT1 7
`define WOM_SEL_OFF 3'h0
`define WOM_SEL_THREE 3'h4

// status register fields
`define WOM_S_THREE 0
`define WOM_S_PULSE 1
`define WOM_S_RUN 2
`define WOM_S_VIOL 3

`endif

// [rtl/wom_pkg.sv]
package wom_pkg;

    typedef enum logic [1:0] {
        WOM_OFF = 2'b00,
        WOM_THREE = 2'b01,
        WOM_PULSE = 2'b10
    } wom_mode_type;

    typedef struct packed {
        logic three_en;
        logic tp_mode1;
        logic pol_low;
        logic dtrig_fall;
        logic pulse_mode1;
        logic [1:0] pwm_sel;
        logic [3:0] grp0_en;
        logic [1:0] grp1_en;
    } wom_out_type;

    typedef struct packed {
        logic mode_we;
        logic viol_clr;
        logic [7:0] data;
    } wom_wr_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
    } wom_apb_state_type;

    typedef struct packed {
        logic [7:0] mode;
        logic viol;
        logic [2:0] shot_prev;
        logic [2:0] dead_trig;
        wom_mode_type sel;
        wom_out_type out;
    } wom_state_type;

endpackage

// [rtl/wom_apb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wom_defs.svh"

module wom_apb
    import wom_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [7:0] mode_i,
    input wire logic [7:0] stat_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    output wom_wr_type wr_o
);

    wom_apb_state_type s_q;
    wom_apb_state_type s_d;
    logic access;

    function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction

    assign access = psel_i & penable_i;
    // zero wait states: answer in the first access cycle
    assign pready_o = access;
    assign prdata_o = s_q.prdata;
    assign pslverr_o = s_q.pslverr & access;

    always_comb begin
        s_d = s_q;
        wr_o = '0;
        if (psel_i && !penable_i) begin
            s_d.prdata = 32'h0000_0000;
            s_d.pslverr = 1'b0;
            if (hit(paddr_i, `WOM_IDX_MODE)) begin
                s_d.prdata = {24'h000000, mode_i};
            end else if (hit(paddr_i, `WOM_IDX_STAT)) begin
                s_d.prdata = {24'h000000, stat_i};
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
        if (access && pwrite_i) begin
            wr_o.data = pwdata_i[7:0];
            if (hit(paddr_i, `WOM_IDX_MODE)) begin
                wr_o.mode_we = 1'b1;
            end else if (hit(paddr_i, `WOM_IDX_STAT)) begin
                wr_o.viol_clr = pwdata_i[`WOM_S_VIOL];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// [rtl/wom_ctrl.sv]
// What this block does
// - select field 100 in bits 2..0 enters three-phase waveform mode.
// - three-phase mode 1 bit 3 sets polarity, 1 low; ignored in mode 0.
// - in three-phase mode bit 4 picks sub-mode 0 or 1.
// - bit 5 is stored but changes nothing in three-phase mode.
// - bit 6 picks dead-time start on both or only falling one-shot edges.
// - in three-phase mode bit 7 enables the waveform outputs.
// - in pulse output mode bit 3 picks pulse mode 0 or 1.
// - in pulse output mode bits 5..4 pick the modulation timer.
// - pulse mode 0 bit 6 enables group one; mode 1 needs it zero.
// - bit 7 enables group zero in pulse mode 0, both groups in mode 1.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "wom_defs.svh"

module wom_ctrl
    import wom_pkg::*;
#(
    parameter logic [7:0] PULSE_CODES = 8'h0E
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic timers_running_i,
    input wire logic [2:0] phase_one_shot_timers_i,
    output wom_mode_type mode_o,
    output wom_out_type out_o,
    output logic [2:0] dead_trig_o,
    output logic [3:0] pulse_group0_outputs_o,
    output logic [1:0] pulse_group1_outputs_o
);

    if (PULSE_CODES[0] || PULSE_CODES[4]) begin : g_bad_codes
        $error("pulse codes may not overlap the off or three-phase codes");
    end

    wom_state_type s_q;
    wom_state_type s_d;
    wom_wr_type wr;
    logic [7:0] stat;
    logic [2:0] rise;
    logic [2:0] fall;

    function automatic wom_mode_type sel_of(input logic [7:0] m);
        logic [2:0] code;
        code = m[`WOM_SEL_HI:`WOM_SEL_LO];
        if (code == `WOM_SEL_THREE) begin
            sel_of = WOM_THREE;
        end else if (PULSE_CODES[code]) begin
            sel_of = WOM_PULSE;
        end else begin
            sel_of = WOM_OFF;
        end
    endfunction

    function automatic wom_out_type decode(input logic [7:0] m);
        wom_mode_type sel;
        sel = sel_of(m);
        decode = '0;
        if (sel == WOM_THREE) begin
            decode.tp_mode1 = m[`WOM_B_TPSUB];
            decode.pol_low = m[`WOM_B_TPSUB] & m[`WOM_B_SUB];
            decode.dtrig_fall = m[`WOM_B_DTRIG];
            decode.three_en = m[`WOM_B_OUT1];
        end else if (sel == WOM_PULSE) begin
            decode.pulse_mode1 = m[`WOM_B_SUB];
            decode.pwm_sel = m[`WOM_B_PWM_HI:`WOM_B_PWM_LO];
            decode.grp0_en = {4{m[`WOM_B_OUT1]}};
            if (m[`WOM_B_SUB]) begin
                decode.grp1_en = {2{m[`WOM_B_OUT1]}};
            end else begin
                decode.grp1_en = {2{m[`WOM_B_DTRIG]}};
            end
        end
    endfunction

    // register bus slave
    wom_apb u_apb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .mode_i(s_q.mode),
        .stat_i(stat),
        .pready_o(pready_o),
        .prdata_o(prdata_o),
        .pslverr_o(pslverr_o),
        .wr_o(wr)
    );

    always_comb begin
        stat = 8'h00;
        stat[`WOM_S_THREE] = (s_q.sel == WOM_THREE);
        stat[`WOM_S_PULSE] = (s_q.sel == WOM_PULSE);
        stat[`WOM_S_RUN] = timers_running_i;
        stat[`WOM_S_VIOL] = s_q.viol;
    end

    // per-phase edge detection of the one-shot pulses
    for (genvar i = 0; i < 3; i++) begin : g_edge
        assign rise[i] = phase_one_shot_timers_i[i] & ~s_q.shot_prev[i];
        assign fall[i] = ~phase_one_shot_timers_i[i] & s_q.shot_prev[i];
    end

    always_comb begin
        s_d = s_q;
        s_d.shot_prev = phase_one_shot_timers_i;
        if (s_q.sel != WOM_THREE) begin
            s_d.dead_trig = 3'h0;
        end else if (s_q.mode[`WOM_B_DTRIG]) begin
            s_d.dead_trig = fall;
        end else begin
            s_d.dead_trig = rise | fall;
        end
        if (wr.mode_we) begin
            s_d.mode = wr.data;
        end
        // set wins over clear
        if (wr.viol_clr) begin
            s_d.viol = 1'b0;
        end
        if (wr.mode_we && timers_running_i && (wr.data[6:0] != s_q.mode[6:0])) begin
            s_d.viol = 1'b1;
        end
        s_d.sel = sel_of(s_d.mode);
        s_d.out = decode(s_d.mode);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.mode <= `WOM_MODE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign mode_o = s_q.sel;
    assign out_o = s_q.out;
    assign dead_trig_o = s_q.dead_trig;
    assign pulse_group0_outputs_o = s_q.out.grp0_en;
    assign pulse_group1_outputs_o = s_q.out.grp1_en;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic three_sel;
    logic pulse_sel;
    logic mode_wr;
    assign three_sel = (s_q.mode[`WOM_SEL_HI:`WOM_SEL_LO] == `WOM_SEL_THREE);
    assign pulse_sel = PULSE_CODES[s_q.mode[`WOM_SEL_HI:`WOM_SEL_LO]];
    assign mode_wr = psel_i && penable_i && pwrite_i && (paddr_i == {`WOM_IDX_MODE, 2'b00});

    sequence s_fall_seen(int k);
        $fell(phase_one_shot_timers_i[k]) && three_sel;
    endsequence

    sequence s_rise_seen(int k);
        $rose(phase_one_shot_timers_i[k]) && three_sel;
    endsequence

    chk_mode_write: assert property (mode_wr |=> s_q.mode == $past(pwdata_i[7:0]))
        else $error("mode register missed a write");

    chk_three_decode: assert property (three_sel |-> mode_o == WOM_THREE)
        else $error("select 100 did not give three-phase mode");

    chk_pol_mode0: assert property (three_sel && !s_q.mode[`WOM_B_TPSUB] |-> !out_o.pol_low)
        else $error("polarity acted in three-phase mode 0");

    chk_pol_mode1: assert property (three_sel && s_q.mode[`WOM_B_TPSUB]
        |-> out_o.pol_low == s_q.mode[`WOM_B_SUB])
        else $error("polarity wrong in three-phase mode 1");

    chk_sub_mode: assert property (three_sel |-> out_o.tp_mode1 == s_q.mode[`WOM_B_TPSUB])
        else $error("three-phase sub-mode wrong");

    chk_bit5_inert: assert property (three_sel && $past(three_sel)
        && s_q.mode[7:6] == $past(s_q.mode[7:6]) && s_q.mode[4:0] == $past(s_q.mode[4:0])
        |-> out_o == $past(out_o))
        else $error("bit 5 changed three-phase outputs");

    chk_dead_fall: assert property (s_fall_seen(0) |=> dead_trig_o[0])
        else $error("falling one-shot edge gave no dead-time trigger");

    chk_dead_rise: assert property (s_rise_seen(1)
        |=> dead_trig_o[1] == !$past(s_q.mode[`WOM_B_DTRIG]))
        else $error("rising one-shot edge trigger wrong");

    chk_wave_gate: assert property (!(three_sel && s_q.mode[`WOM_B_OUT1]) |-> !out_o.three_en)
        else $error("waveform output enabled without bit 7");

    chk_pulse_sub: assert property (pulse_sel |-> out_o.pulse_mode1 == s_q.mode[`WOM_B_SUB])
        else $error("pulse sub-mode wrong");

    chk_pwm_sel: assert property (pulse_sel |-> out_o.pwm_sel == s_q.mode[5:4])
        else $error("modulation timer select wrong");

    chk_grp1_gate: assert property (pulse_sel && !s_q.mode[`WOM_B_SUB]
        |-> pulse_group1_outputs_o == {2{s_q.mode[`WOM_B_DTRIG]}})
        else $error("group one enable wrong in pulse mode 0");

    chk_grp_all: assert property (pulse_sel |-> pulse_group0_outputs_o == {4{s_q.mode[7]}}
        && (!s_q.mode[`WOM_B_SUB] || pulse_group1_outputs_o == {2{s_q.mode[7]}}))
        else $error("bit 7 output enable wrong");

    chk_viol_set: assert property (mode_wr && timers_running_i
        && pwdata_i[6:0] != s_q.mode[6:0] |=> s_q.viol [*2])
        else $error("running-timer write not flagged");

endmodule

`default_nettype wire

// [dv/wom_far.sv]
`timescale 1ns/1ps
`default_nettype none

// timer side: one-shot pulses per phase, timer run flag, trigger counter
module wom_far (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic run_i,
    input wire logic [2:0] dead_trig_i,
    output logic [2:0] shots_o,
    output logic running_o,
    output logic [7:0] trig_cnt_o
);
    logic [3:0] cnt_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            shots_o <= 3'h0;
            running_o <= 1'b0;
            trig_cnt_o <= 8'h00;
        end else begin
            if (cnt_q == 4'hC) begin
                cnt_q <= 4'h0;
            end else if (cnt_q != 4'h0 || fire_i) begin
                cnt_q <= cnt_q + 4'h1;
            end
            // three cycles high per phase, phases in turn
            for (int i = 0; i < 3; i++) begin
                shots_o[i] <= (cnt_q[3:2] == 2'(i)) && (cnt_q[1:0] != 2'h0);
            end
            running_o <= run_i;
            trig_cnt_o <= trig_cnt_o + 8'($countones(dead_trig_i));
        end
    end
endmodule

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wom_defs.svh"

module testbench;
    import wom_pkg::*;
    localparam logic [7:0] PULSE_CODES = 8'h0E;
    localparam logic [11:0] MODE_A = 12'(`WOM_IDX_MODE * 4);
    localparam logic [11:0] STAT_A = 12'(`WOM_IDX_STAT * 4);
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic fire = 1'b0;
    logic run = 1'b0;
    logic pready_o, pslverr_o, running;
    logic [31:0] prdata_o;
    logic [2:0] shots, dead_trig_o;
    logic [3:0] pulse_group0_outputs_o;
    logic [1:0] pulse_group1_outputs_o;
    logic [7:0] trig_cnt;
    wom_mode_type mode_o;
    wom_out_type out_o;
    int mismatches = 0;
    int n_compared = 0;

    always #25 clk_i = ~clk_i;

    wom_ctrl #(.PULSE_CODES(PULSE_CODES)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .timers_running_i(running),
        .phase_one_shot_timers_i(shots), .mode_o(mode_o), .out_o(out_o),
        .dead_trig_o(dead_trig_o), .pulse_group0_outputs_o(pulse_group0_outputs_o),
        .pulse_group1_outputs_o(pulse_group1_outputs_o));

    wom_far u_far (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .run_i(run),
        .dead_trig_i(dead_trig_o), .shots_o(shots), .running_o(running),
        .trig_cnt_o(trig_cnt));

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic put(input logic [7:0] d);
        wom_out_type x;
        wom_mode_type m;
        logic [31:0] r;
        logic e;
        m = (d[2:0] == 3'h4) ? WOM_THREE : (PULSE_CODES[d[2:0]] ? WOM_PULSE : WOM_OFF);
        x = '0;
        if (m == WOM_THREE) begin
            x.three_en = d[7];
            x.tp_mode1 = d[4];
            x.pol_low = d[4] & d[3];
            x.dtrig_fall = d[6];
        end else if (m == WOM_PULSE) begin
            x.pulse_mode1 = d[3];
            x.pwm_sel = d[5:4];
            x.grp0_en = {4{d[7]}};
            x.grp1_en = d[3] ? {2{d[7]}} : {2{d[6]}};
        end
        apb(1'b1, MODE_A, {24'h0, d}, r, e);
        @(negedge clk_i);
        cmp("mode_o", m, mode_o);
        cmp("out_o", x, out_o);
        cmp("group0", x.grp0_en, pulse_group0_outputs_o);
        cmp("group1", x.grp1_en, pulse_group1_outputs_o);
        apb(1'b0, MODE_A, 32'h0, r, e);
        cmp("readback", {24'h0, d}, r);
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        cmp("reset out", 32'h0, {out_o, mode_o, dead_trig_o});
        apb(1'b0, MODE_A, 32'h0, r, e);
        cmp("mode reset", 32'h0, r);
        apb(1'b1, 12'h100, 32'hFF, r, e);
        cmp("unmapped err", 32'h1, e);
        apb(1'b0, 12'h100, 32'h0, r, e);
        cmp("unmapped read", 32'h0, r);
        cmp("unmapped err", 32'h1, {31'h0, e});
        apb(1'b0, STAT_A, 32'h0, r, e);
        cmp("status", 32'h0, r);
    endtask

    task automatic t_three();
        logic [7:0] t[7] = '{8'h84, 8'hA4, 8'h9C, 8'h94, 8'h1C, 8'h8C, 8'hC4};
        for (int k = 0; k < 7; k++) begin
            put(t[k]);
        end
    endtask

    task automatic t_pulse();
        for (int c = 1; c < 4; c++) begin
            put(8'hC0 | 8'(c));
            put(8'h40 | 8'(c));
            put(8'h88 | 8'(c));
            put(8'h08 | 8'(c));
            for (int k = 0; k < 4; k++) begin
                put(8'h80 | 8'(k << 4) | 8'(c));
            end
        end
        put(8'h85);
        put(8'h87);
    endtask

    task automatic t_dead();
        logic [7:0] md[3] = '{8'h84, 8'hC4, 8'h00};
        int ex[3] = '{6, 3, 0};
        logic [7:0] c0;
        for (int k = 0; k < 3; k++) begin
            put(md[k]);
            c0 = trig_cnt;
            @(posedge clk_i);
            fire <= 1'b1;
            @(posedge clk_i);
            fire <= 1'b0;
            repeat (18) @(posedge clk_i);
            @(negedge clk_i);
            cmp("dead triggers", ex[k], trig_cnt - c0);
        end
    endtask

    task automatic t_viol();
        logic [31:0] r;
        logic e;
        put(8'h84);
        @(posedge clk_i);
        run <= 1'b1;
        apb(1'b1, MODE_A, 32'h85, r, e);
        apb(1'b0, STAT_A, 32'h0, r, e);
        cmp("status", 32'h0C, r);
        run <= 1'b0;
        apb(1'b1, STAT_A, 32'h08, r, e);
        apb(1'b0, STAT_A, 32'h0, r, e);
        cmp("status", 32'h00, r);
        put(8'h00);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_three();
        t_pulse();
        t_dead();
        t_viol();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        test_done();
    end
endmodule

`default_nettype wire
